// ### hw/uart_mp_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the serial port
// Assumes: included by bare name from the top module only
// Notes: definitions only
`ifndef UART_MP_CONSTS_SVH
`define UART_MP_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_TXBUF 5'h04
`define OFS_RXBUF 5'h08
`define OFS_STATUS 5'h0c
`define OFS_BAUD 5'h10
`define OFS_SMR4 5'h14

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CTRL_RST 12'h000
`define BAUD_RST 16'h001f
`define SMR4_RST 4'h0
`define TXBUF_RST 9'h000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTRL_W 12
`define TXB_MARKER 8
`define RXB_MARKER 8
`define RXB_OVR 9
`define RXB_FER 10
`define RXB_PER 11
`define ST_TXVAC 0
`define ST_RXFULL 1
`define ST_TXIDLE 2
`define ST_OVR 3

// ------------------------------------------------------------
// timing counts: phase positions in basic-clock ticks, frame lengths and bit indices in bits
// ------------------------------------------------------------
`define HALF_PHASE 4'd7
`define FULL_PHASE 4'd15
`define SYNC_BITS 4'd8
`define ASYNC_LEN_MP 4'd11
`define ASYNC_LEN 4'd10
`define RX_STOP_MP 4'd10
`define RX_STOP 4'd9
`define RX_NINTH 4'd9

`endif

// ### hw/uart_mp_pkg.sv
// Purpose: types shared by the serial port files
// Assumes: constants come from the guarded header
// Notes: control word is laid out with transmit enable at bit 0
package uart_mp_pkg;

  // ------------------------------------------------------------
  // control register layout
  // ------------------------------------------------------------
  typedef struct packed {
    logic parity_odd;
    logic parity_en;
    logic cts_enable;
    logic rts_enable;
    logic clock_edge_polarity;
    logic ext_clock;
    logic sync_mode;
    logic rx_noise_filter_enable;
    logic addr_wait_enable;
    logic mp_format;
    logic rx_on_bit;
    logic transmit_enable;
  } ctrl_t;

  // one received word with its side bits
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic fer;
    logic per;
  } rx_word_t;

  typedef enum logic {ENG_IDLE, ENG_RUN} eng_state_t;
  typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;

endpackage

// ### hw/rx_noise_filter.sv
// Purpose: three-latch agreement filter on the receive line
// Assumes: din already synchronised to clk
// Notes: output changes only when all three samples agree
`timescale 1ns/1ps
module rx_noise_filter (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // sample strobe and data
  input wire logic sample,
  input wire logic din,
  output logic dout
);
  logic [2:0] lat_q;

  // ------------------------------------------------------------
  // cascaded latches, stepped on the 16x tick
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lat
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          lat_q[g] <= 1'b1;
        end else if (ce && sample) begin
          lat_q[g] <= (g == 0) ? din : lat_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // agreement detector; short glitches never reach dout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout <= 1'b1;
    end else if (ce && ((&lat_q) || !(|lat_q))) begin
      dout <= lat_q[0];
    end
  end
endmodule

// ### hw/uart_mp_top.sv
// Purpose: serial port with multiprocessor addressing, rx noise filter, clock-synchronous mode
// Assumes: Avalon-MM slave, one wait cycle per access; pins are asynchronous to clk
// Notes: basic clock tick is clk/(baud+1); one bit lasts sixteen ticks
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_mp_consts.svh"
module uart_mp_top import uart_mp_pkg::*; #(
  parameter int DIV_W = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial data pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  // transfer clock pin, two-way
  input wire logic transfer_clock_in,
  output logic transfer_clock_out,
  output logic transfer_clock_oe,
  // handshake pins, active low
  input wire logic clear_in_pin,
  output logic ready_out_pin
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // byte-lane merge, used by every writable register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // parity bit for a data byte; used by transmitter and receiver
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  ctrl_t ctrl_q;
  logic [DIV_W-1:0] baud_q;
  logic [DIV_W-1:0] baud_cnt_q;
  logic [3:0] smr4_q;
  logic [8:0] txbuf_q;
  logic vacant_q;
  logic [7:0] rxbuf_q;
  logic marker_q, ovr_q, fer_q, per_q, rx_full_q;
  logic tick_q;
  logic rx_s1_q, rx_s2_q, ck_s1_q, ck_s2_q, ck_s3_q, cts_s1_q, cts_s2_q;
  logic rx_filt, rx_line;
  logic [31:0] rd_val;
  logic wr_take, rd_take;
  logic sync_on, ext_on, mp_on, ninth_on, ck_idle, can_start, tx_load;
  logic shift_edge, sample_edge, sdone, arx_done, rx_done, clr_addr_wait;
  rx_word_t rx_res;
  eng_state_t eng_q;
  logic [10:0] sh_q;
  logic [3:0] cnt_q, len_q, phase_q;
  logic sclk_q, txbit_q;
  logic xfer_started_q;
  logic [7:0] rsh_q;
  rx_state_t rxs_q;
  logic [3:0] rcnt_q, rphase_q;
  logic [7:0] rdat_q;
  logic rninth_q;
  logic [3:0] stop_idx;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  assign wr_take = write && !waitrequest;
  assign rd_take = read && !waitrequest;

  // one wait cycle, then a single low cycle that completes the access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
    end else if (ce) begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (address == `OFS_CTRL) begin
      rd_val = {20'h00000, ctrl_q};
    end else if (address == `OFS_TXBUF) begin
      rd_val = {23'h000000, txbuf_q};
    end else if (address == `OFS_RXBUF) begin
      rd_val = {20'h00000, per_q, fer_q, ovr_q, marker_q, rxbuf_q};
    end else if (address == `OFS_STATUS) begin
      rd_val = {28'h0000000, ovr_q, eng_q == ENG_IDLE, rx_full_q, vacant_q};
    end else if (address == `OFS_BAUD) begin
      rd_val = 32'(baud_q);
    end else if (address == `OFS_SMR4) begin
      rd_val = {28'h0000000, smr4_q};
    end
  end

  // read data is captured as waitrequest drops and stands for that cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && waitrequest) begin
      readdata <= rd_val;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // control; a software write beats the hardware clear of address-wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `CTRL_RST;
    end else if (ce) begin
      if (wr_take && address == `OFS_CTRL) begin
        ctrl_q <= ctrl_t'(12'(lane_merge(32'({20'h00000, ctrl_q}), writedata, byteenable)));
      end else if (clr_addr_wait) begin
        ctrl_q.addr_wait_enable <= 1'b0;
      end
    end
  end

  // baud divisor and two-wire condition bits (stored for software only)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_q <= DIV_W'(`BAUD_RST);
      smr4_q <= `SMR4_RST;
    end else if (ce && wr_take) begin
      if (address == `OFS_BAUD) begin
        baud_q <= DIV_W'(lane_merge(32'(baud_q), writedata, byteenable));
      end else if (address == `OFS_SMR4) begin
        smr4_q <= 4'(lane_merge({28'h0000000, smr4_q}, writedata, byteenable));
      end
    end
  end

  // transmit buffer with marker bit; a write in the load cycle keeps it full
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txbuf_q <= `TXBUF_RST;
      vacant_q <= 1'b1;
    end else if (ce) begin
      if (tx_load) begin
        vacant_q <= 1'b1;
      end
      if (wr_take && address == `OFS_TXBUF) begin
        txbuf_q <= 9'(lane_merge({23'h000000, txbuf_q}, writedata, byteenable));
        vacant_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // basic clock and pin synchronisers
  // ------------------------------------------------------------
  // tick at sixteen times the bit rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= (baud_cnt_q >= baud_q);
      baud_cnt_q <= (baud_cnt_q >= baud_q) ? '0 : baud_cnt_q + DIV_W'(1);
    end
  end

  // two flops per pin; ck_s3 only feeds the edge detector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {rx_s1_q, rx_s2_q} <= 2'h3;
      {ck_s1_q, ck_s2_q, ck_s3_q} <= 3'h7;
      {cts_s1_q, cts_s2_q} <= 2'h3;
    end else if (ce) begin
      {rx_s1_q, rx_s2_q} <= {serial_rx_pin, rx_s1_q};
      {ck_s1_q, ck_s2_q, ck_s3_q} <= {transfer_clock_in, ck_s1_q, ck_s2_q};
      {cts_s1_q, cts_s2_q} <= {clear_in_pin, cts_s1_q};
    end
  end

  rx_noise_filter u_filt (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .sample(tick_q),
    .din(rx_s2_q),
    .dout(rx_filt)
  );

  assign rx_line = ctrl_q.rx_noise_filter_enable ? rx_filt : rx_s2_q;

  // ------------------------------------------------------------
  // mode decode and transfer-clock edges
  // ------------------------------------------------------------
  assign sync_on = ctrl_q.sync_mode;
  assign ext_on = ctrl_q.ext_clock;
  assign mp_on = ctrl_q.mp_format && !sync_on;
  assign ninth_on = mp_on || ctrl_q.parity_en;
  assign ck_idle = (ck_s2_q == !ctrl_q.clock_edge_polarity);
  // start needs enable, loaded buffer, clear-to-send and an idle external clock
  assign can_start = ctrl_q.transmit_enable && !vacant_q && (!ctrl_q.cts_enable || !cts_s2_q)
                     && (!sync_on || !ext_on || ck_idle);
  assign tx_load = (eng_q == ENG_IDLE) && can_start;

  // polarity 0: shift on fall, sample on rise; polarity 1 swaps them
  always_comb begin
    if (ext_on) begin
      shift_edge = ctrl_q.clock_edge_polarity ? (ck_s2_q && !ck_s3_q) : (!ck_s2_q && ck_s3_q);
      sample_edge = ctrl_q.clock_edge_polarity ? (!ck_s2_q && ck_s3_q) : (ck_s2_q && !ck_s3_q);
    end else begin
      shift_edge = tick_q && (phase_q == `HALF_PHASE);
      sample_edge = tick_q && (phase_q == `FULL_PHASE);
    end
  end

  // ------------------------------------------------------------
  // transmit engine, also the synchronous shifter
  // ------------------------------------------------------------
  assign sdone = (eng_q == ENG_RUN) && sync_on && sample_edge && (cnt_q == len_q - 4'd1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eng_q <= ENG_IDLE;
      sh_q <= 11'h7ff;
      cnt_q <= 4'h0;
      len_q <= 4'h0;
      phase_q <= 4'h0;
      sclk_q <= 1'b1;
      txbit_q <= 1'b1;
      rsh_q <= 8'h00;
      xfer_started_q <= 1'b0;
    end else if (ce) begin
      case (eng_q)
        ENG_IDLE: begin
          xfer_started_q <= 1'b0;
          phase_q <= 4'h0;
          cnt_q <= 4'h0;
          sclk_q <= !ctrl_q.clock_edge_polarity;
          if (tx_load) begin
            eng_q <= ENG_RUN;
            if (sync_on) begin
              sh_q <= {3'h7, txbuf_q[7:0]};
              len_q <= `SYNC_BITS;
            end else if (mp_on) begin
              sh_q <= {1'b1, txbuf_q[`TXB_MARKER], txbuf_q[7:0], 1'b0};
              len_q <= `ASYNC_LEN_MP;
            end else if (ctrl_q.parity_en) begin
              sh_q <= {1'b1, par_of(txbuf_q[7:0], ctrl_q.parity_odd), txbuf_q[7:0], 1'b0};
              len_q <= `ASYNC_LEN_MP;
            end else begin
              sh_q <= {2'h3, txbuf_q[7:0], 1'b0};
              len_q <= `ASYNC_LEN;
            end
          end
        end
        ENG_RUN: begin
          if (sync_on) begin
            if (!ext_on && tick_q) begin
              phase_q <= phase_q + 4'd1;
            end
            if (shift_edge) begin
              txbit_q <= sh_q[0];
              xfer_started_q <= 1'b1;
              sclk_q <= ctrl_q.clock_edge_polarity;
            end
            if (sample_edge) begin
              rsh_q <= {rx_line, rsh_q[7:1]};
              sh_q <= {1'b1, sh_q[10:1]};
              sclk_q <= !ctrl_q.clock_edge_polarity;
              cnt_q <= cnt_q + 4'd1;
              if (cnt_q == len_q - 4'd1) begin
                eng_q <= ENG_IDLE;
              end
            end
          end else if (tick_q) begin
            phase_q <= phase_q + 4'd1;
            if (phase_q == `FULL_PHASE) begin
              sh_q <= {1'b1, sh_q[10:1]};
              cnt_q <= cnt_q + 4'd1;
              if (cnt_q == len_q - 4'd1) begin
                eng_q <= ENG_IDLE;
              end
            end
          end
        end
        default: eng_q <= ENG_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // asynchronous receiver
  // ------------------------------------------------------------
  assign stop_idx = ninth_on ? `RX_STOP_MP : `RX_STOP;
  assign arx_done = (rxs_q == RX_RUN) && tick_q && (rphase_q == `HALF_PHASE) && (rcnt_q == stop_idx);

  // samples mid-bit; a start bit that is high again at mid-bit is dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxs_q <= RX_IDLE;
      rcnt_q <= 4'h0;
      rphase_q <= 4'h0;
      rdat_q <= 8'h00;
      rninth_q <= 1'b0;
    end else if (ce) begin
      case (rxs_q)
        RX_IDLE: begin
          rcnt_q <= 4'h0;
          rphase_q <= 4'h0;
          if (!sync_on && ctrl_q.rx_on_bit && tick_q && !rx_line) begin
            rxs_q <= RX_RUN;
          end
        end
        RX_RUN: begin
          if (tick_q) begin
            rphase_q <= rphase_q + 4'd1;
            if (rphase_q == `HALF_PHASE) begin
              rcnt_q <= rcnt_q + 4'd1;
              if (rcnt_q == 4'd0 && rx_line) begin
                rxs_q <= RX_IDLE;
              end else if (rcnt_q == stop_idx) begin
                rxs_q <= RX_IDLE;
              end else if (ninth_on && rcnt_q == `RX_NINTH) begin
                rninth_q <= rx_line;
              end else if (rcnt_q != 4'd0) begin
                rdat_q[3'(rcnt_q - 4'd1)] <= rx_line;
              end
            end
          end
        end
        default: rxs_q <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive completion and buffer
  // ------------------------------------------------------------
  always_comb begin
    if (sync_on) begin
      rx_res = '{data: {rx_line, rsh_q[7:1]}, ninth: 1'b0, fer: 1'b0, per: 1'b0};
    end else begin
      rx_res = '{data: rdat_q, ninth: rninth_q, fer: !rx_line,
                 per: ctrl_q.parity_en && !mp_on && (rninth_q != par_of(rdat_q, ctrl_q.parity_odd))};
    end
  end

  assign rx_done = ctrl_q.rx_on_bit && (sdone || arx_done);
  assign clr_addr_wait = rx_done && mp_on && ctrl_q.addr_wait_enable && rx_res.ninth;

  // reading the buffer clears full and overrun; a completion in that cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxbuf_q <= 8'h00;
      marker_q <= 1'b0;
      ovr_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
      rx_full_q <= 1'b0;
    end else if (ce) begin
      if (rd_take && address == `OFS_RXBUF) begin
        rx_full_q <= 1'b0;
        ovr_q <= 1'b0;
      end
      if (rx_done && !(mp_on && ctrl_q.addr_wait_enable && !rx_res.ninth)) begin
        rxbuf_q <= rx_res.data;
        marker_q <= mp_on && rx_res.ninth;
        if (rx_full_q && !(rd_take && address == `OFS_RXBUF)) begin
          ovr_q <= 1'b1;
        end else begin
          rx_full_q <= 1'b1;
          fer_q <= rx_res.fer;
          per_q <= rx_res.per;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // ready stays low while a loaded word waits for the first clock edge, else the master would never clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_out_pin <= 1'b1;
      serial_tx_pin <= 1'b1;
      transfer_clock_out <= 1'b1;
      transfer_clock_oe <= 1'b0;
    end else if (ce) begin
      ready_out_pin <= !(sync_on && ext_on && ctrl_q.rts_enable && ctrl_q.rx_on_bit
                         && !rx_full_q && (eng_q == ENG_IDLE || !xfer_started_q));
      serial_tx_pin <= sync_on ? txbit_q : ((eng_q == ENG_RUN) ? sh_q[0] : 1'b1);
      transfer_clock_out <= sclk_q;
      transfer_clock_oe <= sync_on && !ext_on;
    end
  end

endmodule

// ### verif/uart_mp_top_asserts.sv
// Purpose: port-level relations of the serial port, bound into uart_mp_top
// Assumes: ce high while checked; one wait cycle per bus access
// Notes: register layout is seen only through read data
`timescale 1ns/1ps
module uart_mp_top_asserts #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pins
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic transfer_clock_in,
  input wire logic transfer_clock_out,
  input wire logic transfer_clock_oe,
  input wire logic clear_in_pin,
  input wire logic ready_out_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // read acknowledge cycle
  logic rd_ack;
  assign rd_ack = !waitrequest && read;

  a_ack_one_cycle: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("acknowledge held past one cycle");
  a_req_answered: assert property (ce && waitrequest && (read || write) |=> !waitrequest)
    else $error("request not answered next cycle");
  a_no_idle_ack: assert property (waitrequest && !read && !write |=> waitrequest)
    else $error("acknowledge without request");
  a_hole_reads_zero: assert property (rd_ack && address > 5'h14 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_upper_zero: assert property (rd_ack && address == 5'h00 |-> readdata[31:12] == 20'h0)
    else $error("control upper bits set");
  a_status_upper_zero: assert property (rd_ack && address == 5'h0c |-> readdata[31:4] == 28'h0)
    else $error("status upper bits set");
  a_ready_off_internal: assert property (transfer_clock_oe |-> ready_out_pin)
    else $error("ready active with internal clock");
  // half period is eight basic ticks, never shorter than eight clocks
  a_shift_half_period: assert property (
    transfer_clock_oe && $changed(transfer_clock_out) |=> $stable(transfer_clock_out) [*7])
    else $error("shift clock half period too short");
endmodule
bind uart_mp_top uart_mp_top_asserts #(.DIV_W(DIV_W)) chk_i (.*);

// ### verif/serial_station_model.sv
// Purpose: remote station: async frames, external clock master, clock slave
// Assumes: times in ns; pol 0 only
// Notes: behavioural, driven by bench task calls
`timescale 1ns/1ps
module serial_station_model (
  // lines toward the device
  output logic rx_line,
  output logic xclk,
  // lines from the device
  input wire logic tx_line,
  input wire logic sclk
);
  // idle line high, clock rests high
  initial begin
    rx_line = 1'b1;
    xclk = 1'b1;
  end
  // start, 8 data lsb first, marker, stop
  task automatic send_frame(input logic [7:0] d, input logic n, input int bit_ns);
    logic [10:0] f;
    f = {1'b1, n, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line = f[i];
      #(bit_ns);
    end
  endtask
  // short dip, for noise rejection
  task automatic glitch(input int ns);
    rx_line = 1'b0;
    #(ns);
    rx_line = 1'b1;
  endtask
  // receive one async frame: 8 data plus ninth bit
  task automatic get_frame(output logic [8:0] w, input int bit_ns);
    @(negedge tx_line);
    #(bit_ns * 3 / 2);
    for (int i = 0; i < 9; i++) begin
      w[i] = tx_line;
      #(bit_ns);
    end
  endtask
  // clock master, 160 ns period, only inside the word
  task automatic ext_xfer(input logic [7:0] d, output logic [7:0] q);
    // step off the device clock edge so its data settles before our rising edge
    #1;
    for (int i = 0; i < 8; i++) begin
      xclk = 1'b0;
      rx_line = d[i];
      #80;
      xclk = 1'b1;
      q[i] = tx_line;
      #80;
    end
    rx_line = ~d[7];
  endtask
  // clock slave on the device shift clock
  task automatic int_xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      @(negedge sclk);
      rx_line = d[i];
      @(posedge sclk);
      q[i] = tx_line;
    end
    rx_line = ~d[7];
  endtask
endmodule

// ### verif/uart_multiproc_filter_sync_test.sv
// Purpose: self-checking bench of the serial port
// Assumes: ce and clear-to-send tied active
// Notes: frames at baud 0 last 320 ns a bit
`timescale 1ns/1ps
module uart_multiproc_filter_sync_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, serial_rx_pin, serial_tx_pin, xclk, transfer_clock_out, transfer_clock_oe, ready_out_pin;
  logic [8:0] w;
  logic [7:0] q, d;
  logic [31:0] seed = 32'h40;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int exp_q[$];
  // shared clock pin: device drives it only with oe high
  wire clk_pin = transfer_clock_oe ? transfer_clock_out : xclk;

  uart_mp_top #(.DIV_W(16)) uut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .address(address), .read(read),
    .write(write), .byteenable(4'hf), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .transfer_clock_in(clk_pin),
    .transfer_clock_out(transfer_clock_out), .transfer_clock_oe(transfer_clock_oe), .clear_in_pin(1'b0),
    .ready_out_pin(ready_out_pin));
  serial_station_model st (.rx_line(serial_rx_pin), .xclk(xclk), .tx_line(serial_tx_pin), .sclk(clk_pin));

  always #10 clk = ~clk;
  // hang guard, run needs well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] dat);
    @(posedge clk);
    address <= a;
    writedata <= dat;
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // status: {overrun, rx full}
  task automatic stat(input logic [1:0] exp);
    bus(5'h0c, 1'b0, 32'h0);
    chk({rd[3], rd[1]}, exp);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    bus(5'h10, 1'b0, 32'h0);
    chk(rd, 32'h1f);
    bus(5'h18, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // marker from the written bit; parity enable set but ignored
    bus(5'h10, 1'b1, 32'h0);
    bus(5'h00, 1'b1, 32'h405);
    for (int i = 0; i < 2; i++) begin
      d = 8'(rnd());
      exp_q.push_back({i[0], d});
      fork
        st.get_frame(w, 320);
        bus(5'h04, 1'b1, {23'h0, i[0], d});
      join
      chk(w, exp_q.pop_front());
    end
    // address wait: data frame dropped, marked frame taken
    bus(5'h00, 1'b1, 32'h00e);
    st.send_frame(8'h3c, 1'b0, 320);
    stat(2'b00);
    st.send_frame(d, 1'b1, 320);
    stat(2'b01);
    bus(5'h00, 1'b0, 32'h0);
    chk(rd, 32'h006);
    bus(5'h08, 1'b0, 32'h0);
    chk(rd, {23'h0, 1'b1, d});
    // two unread words: overrun, rx full unchanged
    st.send_frame(8'h5a, 1'b0, 320);
    st.send_frame(8'ha5, 1'b0, 320);
    stat(2'b11);
    bus(5'h08, 1'b0, 32'h0);
    chk(rd[9], 1'b1);
    // filter on, slow rate: a two-tick dip is noise, a frame passes
    bus(5'h10, 1'b1, 32'h3);
    bus(5'h00, 1'b1, 32'h012);
    st.glitch(140);
    repeat (800) @(posedge clk);
    stat(2'b00);
    st.send_frame(d, 1'b1, 1280);
    bus(5'h08, 1'b0, 32'h0);
    chk(rd[7:0], d);
    // internal shift clock starts on buffer load
    bus(5'h10, 1'b1, 32'h0);
    bus(5'h00, 1'b1, 32'h023);
    d = 8'(rnd());
    fork
      st.int_xfer(8'hc3, q);
      bus(5'h04, 1'b1, {24'h0, d});
    join
    chk(q, d);
    repeat (20) @(posedge clk);
    bus(5'h08, 1'b0, 32'h0);
    chk(rd[7:0], 8'hc3);
    // external clock with ready output; checked transmit word loaded first
    bus(5'h00, 1'b1, 32'h163);
    bus(5'h04, 1'b1, {24'h0, d});
    repeat (4) @(posedge clk);
    chk(ready_out_pin, 1'b0);
    fork
      st.ext_xfer(8'h96, q);
      begin
        #410;
        chk(ready_out_pin, 1'b1);
      end
    join
    chk(q, d);
    repeat (20) @(posedge clk);
    bus(5'h08, 1'b0, 32'h0);
    chk(rd[7:0], 8'h96);
    // two-wire requests: condition select cleared, then over half a link clock before raising
    bus(5'h14, 1'b1, 32'h0);
    repeat (5) @(posedge clk);
    bus(5'h14, 1'b1, 32'he);
    bus(5'h14, 1'b0, 32'h0);
    chk(rd, 32'he);
    end_of_test();
  end
endmodule
